// ---- cfg_status_override.sv ----
// Configuration status pins and global override logic
// Notes on behaviour
// - After read strobe pulse, ready flag is driven on top parallel data bit.
// - Init-complete flag driven low during configuration when option enabled.
// - Init-complete flag released before configuration and after initialization.
// - Output-enable override low tri-states all I/O; high leaves design control.
// - Register-clear override low clears all registers; high leaves design control.
// - Overrides and init flag act only when enabled as options.
// - Ready flag high when another byte accepted, low otherwise.
// - Host drives read strobe low to request ready flag; ties high if unused.
//
// Design decisions made here: the register offsets and register access over Wishbone.
`include "cfg_override_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cfg_status_override
  import cfg_override_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Pins from outside
  input  wire logic        readStrobeN,
  input  wire logic        globalOutputEnable,
  input  wire logic        globalRegisterClearN,
  // Top parallel data bit and init flag pins
  output var  logic        topDataOut,
  output var  logic        topDataOe,
  output var  logic        initDoneOut,
  output var  logic        initDoneOe,
  // Overrides toward the user logic
  output var  logic        ioTristateAll,
  output var  logic        regClearAll,
  // Interrupt
  output var  logic        irq
);
  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic       strobeNPrev_r;
  logic       oePrev_r;
  logic       clrPrev_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= 3'h7;
      syncB_r <= 3'h7;
    end else begin
      syncA_r <= {globalRegisterClearN, globalOutputEnable, readStrobeN};
      syncB_r <= syncA_r;
    end
  end
  wire strobeN = syncB_r[0];
  wire oeSync  = syncB_r[1];
  wire clrNSync = syncB_r[2];

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [4:0] irqStat_r;
  logic [4:0] irqMask_r;
  phase_e     phase_r;
  phase_e     phase_nxt;
  logic       rdyShown_r;

  wire access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wrAccess = access & wb_we_i & wb_sel_i[0];
  wire selCtrl  = (wb_adr_i == `REG_CTRL);
  wire selStat  = (wb_adr_i == `REG_STATUS);
  wire selIrqS  = (wb_adr_i == `REG_IRQ_STAT);
  wire selIrqM  = (wb_adr_i == `REG_IRQ_MASK);
  wire wrCtrl   = wrAccess & selCtrl;
  wire wrIrqS   = wrAccess & selIrqS;
  wire wrIrqM   = wrAccess & selIrqM;

  wire initEn   = ctrl_r[`CTRL_BIT_INIT_EN];
  wire oeEn     = ctrl_r[`CTRL_BIT_OE_EN];
  wire clrEn    = ctrl_r[`CTRL_BIT_CLR_EN];
  wire busy     = ctrl_r[`CTRL_BIT_BUSY];
  wire cfgStart = wrCtrl & wb_dat_i[`CTRL_BIT_CFG_START];
  wire cfgEnd   = wrCtrl & wb_dat_i[`CTRL_BIT_CFG_END];

  // Ready flag: high when another byte can be accepted
  wire readyFlag   = (phase_r == PH_CONFIG) & ~busy;
  // Strobe low requests the ready flag on the top data bit
  wire strobeFall  = strobeNPrev_r & ~strobeN;
  wire initRise    = (phase_nxt == PH_USER) & (phase_r == PH_CONFIG);
  wire oeFall      = oePrev_r & ~oeSync;
  wire clrFall     = clrPrev_r & ~clrNSync;
  wire [4:0] evt;
  assign evt[`EVT_INIT_RISE] = initRise;
  assign evt[`EVT_OE_FALL]   = oeFall & oeEn;
  assign evt[`EVT_CLR_FALL]  = clrFall & clrEn;
  assign evt[`EVT_STROBE]    = strobeFall;
  assign evt[`EVT_W - 0]     = 1'b0;
  wire [4:0] irqStatNxt = (irqStat_r & ~({5{wrIrqS}} & wb_dat_i[4:0])) | evt;

  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      PH_IDLE:   if (cfgStart) phase_nxt = PH_CONFIG;
      PH_CONFIG: if (cfgEnd) phase_nxt = PH_USER;
      PH_USER:   if (cfgStart) phase_nxt = PH_CONFIG;
      default:   phase_nxt = PH_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  wire [31:0] statWord = {25'h0, clrNSync, oeSync, readyFlag,
                          rdyShown_r, phase_r == PH_USER,
                          phase_r == PH_CONFIG, ~strobeN};
  wire [31:0] rdData = selCtrl ? {24'h0, ctrl_r} :
                       selStat ? statWord :
                       selIrqS ? {27'h0, irqStat_r} :
                       selIrqM ? {27'h0, irqMask_r} : 32'h0;

  // --------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------
  wire [7:0] ctrl_nxt = {2'h0, wb_dat_i[5], 2'h0, wb_dat_i[2:0]};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // --------------------------------------------------------------
  // Interrupt mask
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqMask_r <= 5'h00;
    end else if (wrIrqM) begin
      irqMask_r <= wb_dat_i[4:0];
    end
  end

  // --------------------------------------------------------------
  // Interrupt status, set wins over clear
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_r <= 5'h00;
    end else begin
      irqStat_r <= irqStatNxt;
    end
  end

  // --------------------------------------------------------------
  // Configuration phase
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // --------------------------------------------------------------
  // Strobe edge detector
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobeNPrev_r <= 1'h1;
    end else begin
      strobeNPrev_r <= strobeN;
    end
  end

  // --------------------------------------------------------------
  // Output-enable pin edge detector
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oePrev_r <= 1'h1;
    end else begin
      oePrev_r <= oeSync;
    end
  end

  // --------------------------------------------------------------
  // Register-clear pin edge detector
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clrPrev_r <= 1'h1;
    end else begin
      clrPrev_r <= clrNSync;
    end
  end

  // --------------------------------------------------------------
  // Bus acknowledge
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'h0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= rdData;
    end
  end

  // --------------------------------------------------------------
  // Ready flag shown on the top bit
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdyShown_r <= 1'h0;
    end else if (strobeFall & (phase_r == PH_CONFIG)) begin
      rdyShown_r <= 1'h1;
    end else if (phase_r != PH_CONFIG) begin
      rdyShown_r <= 1'h0;
    end
  end

  // --------------------------------------------------------------
  // Top data bit value
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      topDataOut <= 1'h0;
    end else begin
      topDataOut <= readyFlag;
    end
  end

  // --------------------------------------------------------------
  // Top data bit drive enable
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      topDataOe <= 1'h0;
    end else begin
      topDataOe <= rdyShown_r & (phase_r == PH_CONFIG);
    end
  end

  // --------------------------------------------------------------
  // Init flag level, low whenever driven
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      initDoneOut <= 1'h0;
    end else begin
      initDoneOut <= 1'h0;
    end
  end

  // --------------------------------------------------------------
  // Init flag drive, released outside configuration
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      initDoneOe <= 1'h0;
    end else begin
      initDoneOe <= initEn & (phase_nxt == PH_CONFIG);
    end
  end

  // --------------------------------------------------------------
  // Output-enable override
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ioTristateAll <= 1'h0;
    end else begin
      ioTristateAll <= oeEn & ~oeSync;
    end
  end

  // --------------------------------------------------------------
  // Register-clear override
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regClearAll <= 1'h0;
    end else begin
      regClearAll <= clrEn & ~clrNSync;
    end
  end

  // --------------------------------------------------------------
  // Interrupt output
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irqStatNxt & irqMask_r);
    end
  end
endmodule
`default_nettype wire

// ---- cfg_override_consts.svh ----
// Offsets, field positions and reset values for the override block
`ifndef CFG_OVERRIDE_CONSTS_SVH
`define CFG_OVERRIDE_CONSTS_SVH
`define REG_CTRL       4'h0
`define REG_STATUS     4'h4
`define REG_IRQ_STAT   4'h8
`define REG_IRQ_MASK   4'hC
`define CTRL_BIT_INIT_EN   0
`define CTRL_BIT_OE_EN     1
`define CTRL_BIT_CLR_EN    2
`define CTRL_BIT_CFG_START 3
`define CTRL_BIT_CFG_END   4
`define CTRL_BIT_BUSY      5
`define CTRL_RESET     8'h00
`define EVT_INIT_RISE  0
`define EVT_OE_FALL    1
`define EVT_CLR_FALL   2
`define EVT_STROBE     3
`define EVT_W          4
`endif

// ---- cfg_override_pkg.sv ----
// Types for the override block
package cfg_override_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_CONFIG, PH_USER} phase_e;
  typedef struct packed {
    logic       dataOut;
    logic       dataOe;
  } pin_drive_s;
endpackage

// ---- cfg_status_override_monitor.sv ----
// Port checker for the override block
`timescale 1ns/1ps
`default_nettype none
module cfg_status_override_monitor (
  input wire logic clk, sys_rst, wb_ack_o, readStrobeN,
  input wire logic globalOutputEnable, globalRegisterClearN,
  input wire logic topDataOut, topDataOe, initDoneOut, initDoneOe,
  input wire logic ioTristateAll, regClearAll
);
  logic [2:0] sinceAck;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) sinceAck <= 3'h7;
    else if (wb_ack_o) sinceAck <= 3'h0;
    else if (sinceAck != 3'h7) sinceAck <= sinceAck + 3'h1;
  a_od_low: assert property (
    initDoneOe |-> !initDoneOut) else $error("flag high");
  a_oe_high: assert property (
    globalOutputEnable [*6] |-> !ioTristateAll) else $error("oe");
  a_clr_high: assert property (
    globalRegisterClearN [*6] |-> !regClearAll) else $error("clr");
  a_strobe_idle: assert property (
    readStrobeN [*8] |-> !$rose(topDataOe)) else $error("strobe");
  a_drive_end: assert property (
    $fell(topDataOe) |-> sinceAck < 3'h4) else $error("drive");
  a_init_start: assert property (
    $rose(initDoneOe) |-> wb_ack_o || sinceAck < 3'h4) else $error("start");
  a_init_end: assert property (
    $fell(initDoneOe) |-> wb_ack_o || sinceAck < 3'h4) else $error("end");
  a_ready_move: assert property (
    topDataOe && $past(topDataOe) && $changed(topDataOut)
    |-> sinceAck < 3'h4) else $error("ready");
  c_drive: cover property ($rose(topDataOe));
  c_user: cover property ($fell(initDoneOe));
  c_tri: cover property ($rose(ioTristateAll));
endmodule
bind cfg_status_override cfg_status_override_monitor u_mon (
  .clk(clk), .sys_rst(sys_rst), .wb_ack_o(wb_ack_o),
  .readStrobeN(readStrobeN), .globalOutputEnable(globalOutputEnable),
  .globalRegisterClearN(globalRegisterClearN), .topDataOut(topDataOut),
  .topDataOe(topDataOe), .initDoneOut(initDoneOut),
  .initDoneOe(initDoneOe), .ioTristateAll(ioTristateAll),
  .regClearAll(regClearAll));
`default_nettype wire

// ---- cfg_host_model.sv ----
// Host side: pull-up, released data bit, read strobe
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input  wire logic clk, initDoneOut, initDoneOe, topDataOut, topDataOe,
  output var  logic readStrobeN = 1'h1, userSeen = 1'h0, topLevel = 1'h0,
  output var  logic initLevel,
  output var  logic [3:0] testPortPins = 4'h0 // Held stable
);
  logic lastInit = 1'h1;
  assign initLevel = initDoneOe ? initDoneOut : 1'h1;
  always @(posedge clk) begin
    topLevel <= topDataOe ? topDataOut : ~topLevel;
    if (initLevel && !lastInit) userSeen <= 1'h1;
    lastInit <= initLevel;
  end
  task automatic strobe();
    readStrobeN <= 1'h0;
    repeat (4) @(posedge clk);
    readStrobeN <= 1'h1;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Bench for the override block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic globalOutputEnable = 1, globalRegisterClearN = 1;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, topDataOut, topDataOe, initDoneOut, initDoneOe, irq;
  logic ioTristateAll, regClearAll, readStrobeN, initLevel, topLevel;
  logic userSeen;
  logic [3:0] testPortPins;
  int mdlStat = 0, mdlMask = 0;
  logic [1:0] e, p;
  int failures = 0, cmpCount = 0, cycN = 0;
  cfg_status_override u_dut (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .readStrobeN(readStrobeN), .globalOutputEnable(globalOutputEnable),
    .globalRegisterClearN(globalRegisterClearN), .topDataOut(topDataOut),
    .topDataOe(topDataOe), .initDoneOut(initDoneOut),
    .initDoneOe(initDoneOe), .ioTristateAll(ioTristateAll),
    .regClearAll(regClearAll), .irq(irq));
  cfg_host_model u_host (
    .clk(clk), .initDoneOut(initDoneOut), .initDoneOe(initDoneOe),
    .topDataOut(topDataOut), .topDataOe(topDataOe),
    .readStrobeN(readStrobeN), .userSeen(userSeen), .topLevel(topLevel),
    .initLevel(initLevel), .testPortPins(testPortPins));
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cycN > 3000) begin failures++; end_of_test(); end
  task automatic ck(input logic [31:0] g, x);
    cmpCount++;
    if (g !== x) begin failures++; $display("[ERR] %0t got %h", $time, g); end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    do @(posedge clk); while (!wb_ack_o);
    q = wb_dat_o; wb_cyc_i <= 0; wb_stb_i <= 0;
    @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("cmp %0d fail %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(25));
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    wb(0, 4'h4, 0); ck(q, 32'h60);
    wb(0, 4'h2, 0); ck(q, 0);
    for (int i = 0; i < 8; i++) begin
      {e, p} = 4'($urandom);
      wb(1, 4'h0, {29'h0, e, 1'h1});
      globalOutputEnable <= p[0];
      globalRegisterClearN <= p[1];
      repeat (6) @(posedge clk);
      ck(ioTristateAll, e[0] & ~p[0]);
      ck(regClearAll, e[1] & ~p[1]);
    end
    {globalOutputEnable, globalRegisterClearN} <= 2'h3;
    repeat (6) @(posedge clk);
    wb(1, 4'h8, 32'h1F); wb(1, 4'hC, 0);
    mdlStat = 0; mdlMask = 0;
    wb(1, 4'h0, 32'h0F); @(posedge clk);
    ck(initLevel, 0); ck(topDataOe, 0);
    u_host.strobe(); repeat (6) @(posedge clk);
    mdlStat |= 32'h8;
    ck(topLevel, 1); ck(topDataOe, 1);
    wb(1, 4'h0, 32'h27); repeat (3) @(posedge clk);
    ck(topLevel, 0);
    wb(1, 4'h0, 32'h17); repeat (3) @(posedge clk);
    mdlStat |= 32'h1;
    ck(initLevel, 1); ck(userSeen, 1); ck(topDataOe, 0);
    wb(0, 4'h8, 0); ck(q, mdlStat); ck(irq, (mdlStat & mdlMask) != 0);
    wb(1, 4'hC, 32'h1F); mdlMask = 32'h1F;
    @(posedge clk); ck(irq, (mdlStat & mdlMask) != 0);
    {globalOutputEnable, globalRegisterClearN} <= 2'h0;
    repeat (6) @(posedge clk); mdlStat |= 32'h6;
    ck(ioTristateAll, 1); ck(regClearAll, 1);
    {globalOutputEnable, globalRegisterClearN} <= 2'h3;
    repeat (6) @(posedge clk);
    ck(ioTristateAll, 0); ck(regClearAll, 0);
    wb(0, 4'h8, 0); ck(q, mdlStat); ck(irq, (mdlStat & mdlMask) != 0);
    wb(1, 4'h8, 32'hF); mdlStat = 0;
    wb(0, 4'h8, 0); ck(q, mdlStat); ck(irq, (mdlStat & mdlMask) != 0);
    ck(testPortPins, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
